// [rtl/usb_ep_device.sv]
// Device end: endpoint control, masks and buffers behind a CPU register port
// Behaviour
// - Forced control halt stalls endpoint 0 until SETUP
// - Event masks gate flags onto interrupt, reset zero
// - Bus reset interrupts only when select bit set
// - Endpoint 0 rx length read, tx length written
// - Tx ready starts IN; cleared by success, SETUP
// - Tx done flag NAKs IN; write zero clears
// - Rx full set on store; NAK until cleared
// - Rx done set on OUT/SETUP; NAKs OUT
// - Endpoint transfer done NAKs packets unless stalled
// - IN endpoint valid arms send; cleared on success
// - OUT endpoint valid set on store; NAK until cleared
// - Size code selects 8 to 64 bytes
// - Done flag interrupts only with its enable
// - Direction bit: one IN, zero OUT
// - Stall bit latches halt on next packet
// - Latched halt cleared by host request or disable
// - Software clears stall bits after bus reset
// - Type field: off, bulk or interrupt
// - Packet length: tx count or received count
// - Buffers in 64-byte RAM at 8-byte bases
// - Interface select bits per endpoint
// - Data registers read OUT, write IN buffer
// - Enable freezes config; clearing resets transfer state
`timescale 1ns/1ps
`default_nettype none
module usb_ep_device
  import usb_ep_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  usb_link_if.device      link,
  input  wire logic       reg_sel,
  input  wire logic       reg_wr,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       setup_flag,
  input  wire logic       frame_start_flag,
  input  wire logic       cfg_change_flag,
  input  wire logic       bus_reset_flag,
  input  wire logic       wake_flag,
  input  wire logic       sleep_flag,
  input  wire logic       bus_reset_irq_select,
  output logic            irq
);
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RX   = 2'b01,
    D_TX   = 2'b10,
    D_HS   = 2'b11
  } dstate_e;
  typedef struct packed {
    dstate_e        st;
    logic [6:0]     cnt;
    logic [6:0]     len;
    logic [2:0]     ep;
    hs_e            hs;
    logic           store;
    logic [7:0]     irq_mask;
    logic           enable;
    logic           force_halt;
    logic [3:0]     rx_len;
    logic [3:0]     tx_len;
    logic           tx_ready;
    logic           tx_done;
    logic           rx_full;
    logic           rx_done;
    logic [7:0][7:0] in_buf;
    logic [7:0][7:0] out_buf;
    logic [3:0][1:0] mode;
    logic [3:0][1:0] size;
    logic [3:0][2:0] base;
    logic [3:0][6:0] pkt_len;
    logic [3:0]     dir;
    logic [3:0]     irq_en;
    logic [3:0]     valid;
    logic [3:0]     done;
    logic [3:0]     stall;
    logic [3:0]     halted;
    logic [3:0]     iface;
    logic [7:0]     rdata;
    logic           irq;
    logic           d_dat_valid;
    logic [7:0]     d_dat;
    logic           hs_valid;
    hs_e            hs_code;
  } dev_s;
  dev_s       r;
  dev_s       next_r;
  logic       ram_we;
  logic [5:0] ram_wa;
  logic [7:0] ram_wd;
  logic [5:0] ram_la;
  logic [7:0] ram_link_rd;
  logic [7:0] ram_cpu_rd;
  logic [1:0] ke;

  // Shared endpoint buffer RAM
  byte_ram #(.WIDTH(8), .DEPTH(RAM_BYTES)) u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (ram_we),
    .waddr   (ram_wa),
    .wdata   (ram_wd),
    .raddr_a (ram_la),
    .rdata_a (ram_link_rd),
    .raddr_b (reg_addr[5:0]),
    .rdata_b (ram_cpu_rd)
  );

  assign ke     = 2'(r.ep - 3'h1);
  assign ram_la = {r.base[ke], 3'b000} + r.cnt[5:0];

  // Register access, link sequencing and interrupt combine
  always_comb
  begin
    logic [7:0] rd;
    logic [1:0] k;
    logic       ep_ok;
    logic       io;
    logic [5:0] fl;
    next_r = r;
    rd = REG_RESET;
    k = 2'(link.tok_ep - 3'h1);
    ep_ok = link.tok_ep >= 3'h1 && link.tok_ep <= 3'h4;
    io = link.tok_kind == TOK_IN || link.tok_kind == TOK_OUT;
    fl = {sleep_flag, wake_flag, bus_reset_flag & bus_reset_irq_select, cfg_change_flag,
          frame_start_flag, setup_flag};
    ram_we = 1'b0;
    ram_wa = reg_addr[5:0];
    ram_wd = reg_wdata;
    next_r.d_dat_valid = 1'b0;
    next_r.hs_valid = 1'b0;
    // Read mux
    case (reg_addr)
      OFS_IRQ_MASK: rd = r.irq_mask;
      OFS_EP0_CSR:  rd = {r.rx_done, r.rx_full, r.tx_done, r.tx_ready, r.rx_len};
      OFS_CTL:      rd = {7'h00, r.enable};
      OFS_BASE12:   rd = {1'b0, r.base[1], 1'b0, r.base[0]};
      OFS_BASE34:   rd = {1'b0, r.base[3], 1'b0, r.base[2]};
      OFS_IFACE:    rd = {4'h0, r.iface};
      OFS_SIZE:     rd = r.size;
      default:      rd = REG_RESET;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      if (reg_addr == OFS_EP_CSR + 7'(i))
        rd = {r.mode[i], r.stall[i], r.dir[i], r.irq_en[i], r.valid[i], r.done[i], 1'b0};
      if (reg_addr == OFS_EP_LEN + 7'(i))
        rd = {1'b0, r.pkt_len[i]};
    end
    if (reg_addr[6:3] == OFS_EP0_DATA[6:3])
      rd = r.out_buf[reg_addr[2:0]];
    if (reg_addr[6])
      rd = ram_cpu_rd;
    if (reg_sel && !reg_wr)
      next_r.rdata = rd;
    // Software writes; hardware sets below win over these clears
    if (reg_sel && reg_wr)
    begin
      case (reg_addr)
        OFS_IRQ_MASK: next_r.irq_mask = reg_wdata & MASK_BITS;
        OFS_CTL:
        begin
          next_r.enable = reg_wdata[CTL_ENABLE];
          if (reg_wdata[CTL_HALT])
            next_r.force_halt = 1'b1;
        end
        OFS_EP0_CSR:
        begin
          next_r.tx_len = reg_wdata[3:0];
          next_r.tx_ready = reg_wdata[EP0_TX_READY];
          next_r.tx_done = r.tx_done & reg_wdata[EP0_TX_DONE];
          next_r.rx_full = r.rx_full & reg_wdata[EP0_RX_FULL];
          next_r.rx_done = r.rx_done & reg_wdata[EP0_RX_DONE];
        end
        OFS_BASE12:
          if (!r.enable)
            next_r.base[1:0] = {reg_wdata[6:4], reg_wdata[2:0]};
        OFS_BASE34:
          if (!r.enable)
            next_r.base[3:2] = {reg_wdata[6:4], reg_wdata[2:0]};
        OFS_IFACE:
          if (!r.enable)
            next_r.iface = reg_wdata[3:0];
        OFS_SIZE:
          if (!r.enable)
            next_r.size = reg_wdata;
        default: ;
      endcase
      for (int i = 0; i < 4; i++)
      begin
        if (reg_addr == OFS_EP_CSR + 7'(i))
        begin
          if (!r.enable)
          begin
            next_r.mode[i] = reg_wdata[7:6];
            next_r.dir[i] = reg_wdata[CSR_DIR];
          end
          next_r.stall[i] = reg_wdata[CSR_STALL];
          next_r.irq_en[i] = reg_wdata[CSR_IRQEN];
          next_r.valid[i] = reg_wdata[CSR_VALID] & (r.dir[i] | r.valid[i]);
          next_r.done[i] = r.done[i] & reg_wdata[CSR_DONE];
        end
        if (reg_addr == OFS_EP_LEN + 7'(i))
          next_r.pkt_len[i] = reg_wdata[6:0];
      end
      if (reg_addr[6:3] == OFS_EP0_DATA[6:3])
        next_r.in_buf[reg_addr[2:0]] = reg_wdata;
      ram_we = reg_addr[6];
    end
    // Link sequencing
    case (r.st)
      D_IDLE:
        if (link.tok_valid && r.enable)
        begin
          next_r.ep = link.tok_ep;
          next_r.len = link.tok_len;
          next_r.cnt = 7'h00;
          next_r.store = 1'b0;
          next_r.hs = HS_NONE;
          next_r.st = (link.tok_kind == TOK_OUT || link.tok_kind == TOK_SETUP) ? D_RX : D_HS;
          if (link.tok_kind == TOK_SETUP && link.tok_ep == 3'h0)
          begin
            next_r.store = 1'b1;
            next_r.hs = HS_ACK;
            next_r.force_halt = 1'b0;
            next_r.tx_ready = 1'b0;
          end
          else if (link.tok_kind == TOK_CLEAR_HALT)
          begin
            if (ep_ok)
              next_r.halted[k] = 1'b0;
            next_r.hs = HS_ACK;
          end
          else if (link.tok_ep == 3'h0 && io)
          begin
            if (r.force_halt)
              next_r.hs = HS_STALL;
            else if (link.tok_kind == TOK_IN)
            begin
              if (!r.tx_ready || r.tx_done)
                next_r.hs = HS_NAK;
              else
              begin
                next_r.st = D_TX;
                next_r.hs = HS_ACK;
                next_r.len = ({3'h0, r.tx_len} > EP0_BYTES) ? EP0_BYTES : {3'h0, r.tx_len};
              end
            end
            else if (r.rx_full || r.rx_done)
              next_r.hs = HS_NAK;
            else
            begin
              next_r.store = 1'b1;
              next_r.hs = HS_ACK;
            end
          end
          else if (ep_ok && io && r.mode[k] != MODE_OFF && r.dir[k] == (link.tok_kind == TOK_IN))
          begin
            if (r.halted[k])
              next_r.hs = HS_STALL;
            else if (r.stall[k])
            begin
              next_r.halted[k] = 1'b1;
              next_r.stall[k] = 1'b0;
              next_r.hs = HS_STALL;
            end
            else if (r.done[k])
              next_r.hs = HS_NAK;
            else if (r.dir[k])
            begin
              if (!r.valid[k])
                next_r.hs = HS_NAK;
              else
              begin
                next_r.st = D_TX;
                next_r.hs = HS_ACK;
                next_r.len = (r.pkt_len[k] > size_bytes(r.size[k])) ? size_bytes(r.size[k])
                                                                     : r.pkt_len[k];
              end
            end
            else if (r.valid[k])
              next_r.hs = HS_NAK;
            else
            begin
              next_r.store = 1'b1;
              next_r.hs = HS_ACK;
            end
          end
        end
      D_RX:
        if (r.cnt == r.len)
        begin
          next_r.st = D_HS;
          if (r.store && r.ep == 3'h0)
          begin
            next_r.rx_full = 1'b1;
            next_r.rx_done = 1'b1;
            next_r.rx_len = (r.len > EP0_BYTES) ? 4'h8 : r.len[3:0];
          end
          else if (r.store)
          begin
            next_r.valid[ke] = 1'b1;
            next_r.done[ke] = 1'b1;
            next_r.pkt_len[ke] = r.len;
          end
        end
        else if (link.h_dat_valid)
        begin
          next_r.cnt = r.cnt + 7'h01;
          if (r.store && r.ep == 3'h0 && r.cnt < EP0_BYTES)
            next_r.out_buf[r.cnt[2:0]] = link.h_dat;
          if (r.store && r.ep != 3'h0 && r.cnt < size_bytes(r.size[ke]))
          begin
            ram_we = 1'b1;
            ram_wa = ram_la;
            ram_wd = link.h_dat;
          end
        end
      D_TX:
        if (r.cnt == r.len)
        begin
          next_r.st = D_HS;
          if (r.ep == 3'h0)
          begin
            next_r.tx_ready = 1'b0;
            next_r.tx_done = 1'b1;
          end
          else
          begin
            next_r.valid[ke] = 1'b0;
            next_r.done[ke] = 1'b1;
          end
        end
        else
        begin
          next_r.d_dat_valid = 1'b1;
          next_r.d_dat = (r.ep == 3'h0) ? r.in_buf[r.cnt[2:0]] : ram_link_rd;
          next_r.cnt = r.cnt + 7'h01;
        end
      D_HS:
      begin
        next_r.hs_valid = 1'b1;
        next_r.hs_code = r.hs;
        next_r.st = D_IDLE;
      end
      default: next_r.st = D_IDLE;
    endcase
    // Disabling the function resets its transfer state
    if (reg_sel && reg_wr && reg_addr == OFS_CTL && !reg_wdata[CTL_ENABLE] && r.enable)
    begin
      next_r.st = D_IDLE;
      next_r.halted = 4'h0;
      next_r.done = 4'h0;
      next_r.valid = 4'h0;
      next_r.tx_ready = 1'b0;
      next_r.tx_done = 1'b0;
      next_r.rx_full = 1'b0;
      next_r.rx_done = 1'b0;
      next_r.d_dat_valid = 1'b0;
      next_r.hs_valid = 1'b0;
    end
    next_r.irq = |(r.irq_mask[5:0] & fl) | |(r.done & r.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign reg_rdata        = r.rdata;
  assign irq              = r.irq;
  assign link.d_dat_valid = r.d_dat_valid;
  assign link.d_dat       = r.d_dat;
  assign link.hs_valid    = r.hs_valid;
  assign link.hs_code     = r.hs_code;
endmodule : usb_ep_device
`default_nettype wire

// [rtl/usb_ep_pkg.sv]
// Shared constants and types for the USB endpoint control link
package usb_ep_pkg;
  localparam logic [6:0] EP0_BYTES = 7'h08;
  localparam int         RAM_BYTES = 64;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Device register indices
  localparam logic [6:0] OFS_IRQ_MASK = 7'h00;
  localparam logic [6:0] OFS_EP0_CSR  = 7'h01;
  localparam logic [6:0] OFS_CTL      = 7'h02;
  localparam logic [6:0] OFS_EP_CSR   = 7'h04;
  localparam logic [6:0] OFS_EP_LEN   = 7'h08;
  localparam logic [6:0] OFS_BASE12   = 7'h0C;
  localparam logic [6:0] OFS_BASE34   = 7'h0D;
  localparam logic [6:0] OFS_IFACE    = 7'h0E;
  localparam logic [6:0] OFS_SIZE     = 7'h0F;
  localparam logic [6:0] OFS_EP0_DATA = 7'h18;
  // Event mask bits, low six bits of the mask register
  localparam logic [7:0] MASK_BITS = 8'h3F;
  // Endpoint csr fields
  localparam int CSR_DONE  = 1;
  localparam int CSR_VALID = 2;
  localparam int CSR_IRQEN = 3;
  localparam int CSR_DIR   = 4;
  localparam int CSR_STALL = 5;
  // Control endpoint csr fields
  localparam int EP0_TX_READY = 4;
  localparam int EP0_TX_DONE  = 5;
  localparam int EP0_RX_FULL  = 6;
  localparam int EP0_RX_DONE  = 7;
  // Control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_HALT   = 1;
  localparam logic [1:0] MODE_OFF = 2'b00;
  // Host register byte addresses, and the data window page matched on address bits 11:8
  localparam logic [11:0] HOFS_CMD  = 12'h000;
  localparam logic [11:0] HOFS_STAT = 12'h004;
  localparam logic [3:0]  HOFS_DATA = 4'h1;
  typedef enum logic [2:0] {
    TOK_NONE       = 3'b000,
    TOK_SETUP      = 3'b001,
    TOK_IN         = 3'b010,
    TOK_OUT        = 3'b011,
    TOK_CLEAR_HALT = 3'b100
  } tok_e;
  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_ACK   = 2'b01,
    HS_NAK   = 2'b10,
    HS_STALL = 2'b11
  } hs_e;
  // Buffer size code to bytes: 8, 16, 32, 64
  function automatic logic [6:0] size_bytes(input logic [1:0] code);
    return 7'h08 << code;
  endfunction : size_bytes
endpackage : usb_ep_pkg

// [rtl/usb_link_if.sv]
// Token, data and handshake link between host and device ends
`timescale 1ns/1ps
`default_nettype none
interface usb_link_if;
  logic       tok_valid;
  logic [2:0] tok_kind;
  logic [2:0] tok_ep;
  logic [6:0] tok_len;
  logic       h_dat_valid;
  logic [7:0] h_dat;
  logic       d_dat_valid;
  logic [7:0] d_dat;
  logic       hs_valid;
  logic [1:0] hs_code;
  modport device (input tok_valid, tok_kind, tok_ep, tok_len, h_dat_valid, h_dat,
                  output d_dat_valid, d_dat, hs_valid, hs_code);
  modport host (output tok_valid, tok_kind, tok_ep, tok_len, h_dat_valid, h_dat,
                input d_dat_valid, d_dat, hs_valid, hs_code);
endinterface : usb_link_if
`default_nettype wire

// [rtl/byte_ram.sv]
// Flip-flop byte buffer with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module byte_ram
  import usb_ep_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = RAM_BYTES,
  localparam int AW = $clog2(DEPTH)
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr_a,
  output logic      [WIDTH-1:0] rdata_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_b
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } ram_s;
  ram_s r;
  ram_s next_r;

  // Write port
  always_comb
  begin
    next_r = r;
    if (we)
      next_r.mem[waddr] = wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign rdata_a = r.mem[raddr_a];
  assign rdata_b = r.mem[raddr_b];
endmodule : byte_ram
`default_nettype wire

// [rtl/usb_ep_host.sv]
// Host end: APB-commanded token, data and handshake sequencer
`timescale 1ns/1ps
`default_nettype none
module usb_ep_host
  import usb_ep_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  usb_link_if.host         link
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b10
  } hstate_e;
  typedef struct packed {
    hstate_e     st;
    tok_e        kind;
    logic [2:0]  ep;
    logic [6:0]  len;
    logic [6:0]  cnt;
    logic [6:0]  rx_cnt;
    hs_e         hs;
    logic        got_hs;
    logic        busy;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tok_valid;
    logic        h_dat_valid;
    logic [7:0]  h_dat;
  } host_s;
  host_s      r;
  host_s      next_r;
  logic       ram_we;
  logic [5:0] ram_wa;
  logic [7:0] ram_wd;
  logic [7:0] ram_tx;
  logic [7:0] ram_apb;
  logic       is_data;
  logic       mapped;

  // Packet buffer for OUT data sent and IN data received
  byte_ram #(.WIDTH(8), .DEPTH(RAM_BYTES)) u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (ram_we),
    .waddr   (ram_wa),
    .wdata   (ram_wd),
    .raddr_a (r.cnt[5:0]),
    .rdata_a (ram_tx),
    .raddr_b (paddr[7:2]),
    .rdata_b (ram_apb)
  );

  assign is_data = paddr[11:8] == HOFS_DATA && paddr[1:0] == 2'b00;
  assign mapped  = is_data || paddr == HOFS_CMD || paddr == HOFS_STAT;

  // APB slave and link sequencing
  always_comb
  begin
    logic acc;
    next_r = r;
    acc = psel && penable && r.pready && mapped;
    ram_we = 1'b0;
    ram_wa = paddr[7:2];
    ram_wd = pwdata[7:0];
    next_r.tok_valid = 1'b0;
    next_r.h_dat_valid = 1'b0;
    next_r.pready = psel && !penable;
    next_r.pslverr = psel && !penable && !mapped;
    // Read data prepared in the setup cycle
    if (psel && !penable)
    begin
      if (paddr == HOFS_CMD)
        next_r.prdata = 32'({r.len, 1'b0, r.ep, 1'b0, r.kind});
      else if (paddr == HOFS_STAT)
        next_r.prdata = 32'({r.rx_cnt, 2'b00, r.hs, 2'b00, r.got_hs, r.busy});
      else if (is_data)
        next_r.prdata = {24'h000000, ram_apb};
      else
        next_r.prdata = 32'h00000000;
    end
    // Command start and buffer load, refused while busy
    if (acc && pwrite && !r.busy)
    begin
      if (paddr == HOFS_CMD)
      begin
        next_r.kind = tok_e'(pwdata[2:0]);
        next_r.ep = pwdata[6:4];
        next_r.len = pwdata[14:8];
        next_r.cnt = 7'h00;
        next_r.rx_cnt = 7'h00;
        next_r.got_hs = 1'b0;
        next_r.busy = 1'b1;
        next_r.tok_valid = 1'b1;
        next_r.st = (pwdata[2:0] == TOK_OUT || pwdata[2:0] == TOK_SETUP) ? H_SEND : H_WAIT;
      end
      ram_we = is_data;
    end
    case (r.st)
      H_IDLE: ;
      H_SEND:
        if (r.cnt == r.len)
          next_r.st = H_WAIT;
        else
        begin
          next_r.h_dat_valid = 1'b1;
          next_r.h_dat = ram_tx;
          next_r.cnt = r.cnt + 7'h01;
        end
      H_WAIT:
      begin
        if (link.d_dat_valid)
        begin
          ram_we = 1'b1;
          ram_wa = r.rx_cnt[5:0];
          ram_wd = link.d_dat;
          next_r.rx_cnt = r.rx_cnt + 7'h01;
        end
        if (link.hs_valid)
        begin
          next_r.hs = hs_e'(link.hs_code);
          next_r.got_hs = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = H_IDLE;
        end
      end
      default: next_r.st = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign prdata           = r.prdata;
  assign pready           = r.pready;
  assign pslverr          = r.pslverr;
  assign link.tok_valid   = r.tok_valid;
  assign link.tok_kind    = r.kind;
  assign link.tok_ep      = r.ep;
  assign link.tok_len     = r.len;
  assign link.h_dat_valid = r.h_dat_valid;
  assign link.h_dat       = r.h_dat;
endmodule : usb_ep_host
`default_nettype wire

// [verification/usb_link_props.sv]
// Checker for the link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module usb_link_props
  import usb_ep_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       tok_valid,
  input wire logic [2:0] tok_kind,
  input wire logic [6:0] tok_len,
  input wire logic       h_dat_valid,
  input wire logic       d_dat_valid,
  input wire logic       hs_valid,
  input wire logic [1:0] hs_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Final byte of an IN or OUT data stream
  sequence in_end;
    d_dat_valid ##1 !d_dat_valid;
  endsequence
  sequence out_end;
    h_dat_valid ##1 !h_dat_valid;
  endsequence
  // Pulses, answer timing and data direction on the link
  tok_pulse_a: assert property (tok_valid |=> !tok_valid)
    else $error("token not a pulse");
  hs_pulse_a: assert property (hs_valid |=> !hs_valid)
    else $error("handshake not a pulse");
  hs_bound_a: assert property (tok_valid |-> ##[2:200] hs_valid)
    else $error("token got no handshake");
  // A zero-length IN that is accepted closes with its handshake one cycle later
  in_answer_a: assert property (tok_valid && tok_kind == TOK_IN |-> (##2 (d_dat_valid || hs_valid)) or (##3 hs_valid))
    else $error("IN token not answered at cycle 2");
  in_ack_a: assert property (in_end |-> ##[0:1] (hs_valid && hs_code == HS_ACK))
    else $error("IN data not closed by ACK");
  out_start_a: assert property (tok_valid && tok_kind == TOK_OUT && tok_len != 7'h00 |=> h_dat_valid)
    else $error("OUT data did not follow token");
  out_ack_a: assert property (out_end |-> ##2 hs_valid)
    else $error("OUT data not closed by handshake");
  one_way_a: assert property (!(h_dat_valid && d_dat_valid))
    else $error("data in both directions");
endmodule : usb_link_props
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench: host end commands transfers to the device end
`timescale 1ns/1ps
`default_nettype none
module testbench
  import usb_ep_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        reg_sel, reg_wr, rsel, irq, psel, penable, pwrite, pready, pslverr;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, b;
  logic [5:0]  flg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          i;
  logic [7:0]  q[$];
  usb_link_if lnk();
  usb_ep_device usb_ep_device_inst (.pclk(pclk), .presetn(presetn), .link(lnk), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .setup_flag(flg[0]),
    .frame_start_flag(flg[1]), .cfg_change_flag(flg[2]), .bus_reset_flag(flg[3]), .wake_flag(flg[4]),
    .sleep_flag(flg[5]), .bus_reset_irq_select(rsel), .irq(irq));
  usb_ep_host usb_ep_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(lnk));
  usb_link_props usb_link_props_inst (.pclk(pclk), .presetn(presetn), .tok_valid(lnk.tok_valid),
    .tok_kind(lnk.tok_kind), .tok_len(lnk.tok_len), .h_dat_valid(lnk.h_dat_valid),
    .d_dat_valid(lnk.d_dat_valid), .hs_valid(lnk.hs_valid), .hs_code(lnk.hs_code));
  // Bus clock
  always #12.5 pclk = ~pclk;
  // Verdict and checking helpers
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic hang();
    miscompares++;
    summarize();
  endtask : hang
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  // Device register port access, one cycle each
  task automatic dev(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge pclk);
    reg_sel <= 1'b1;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge pclk);
    reg_sel <= 1'b0;
    #1;
  endtask : dev
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    dev(1'b0, a, 8'h00);
    chk("reg", 32'(e), 32'(reg_rdata));
  endtask : rd
  // APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 16 && pready !== 1'b1; j++)
      @(posedge pclk);
    r = prdata;
    chk("pslverr", 32'(a != HOFS_CMD && a != HOFS_STAT && a[11:8] != HOFS_DATA), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      hang();
  endtask : apb
  // Host transfer: command, poll status, compare handshake code
  task automatic xfer(input logic [2:0] k, input logic [2:0] ep, input logic [6:0] n, input logic [1:0] e);
    int j;
    apb(1'b1, HOFS_CMD, {17'h0, n, 1'b0, ep, 1'b0, k});
    for (j = 0; j < 100; j++)
    begin
      apb(1'b0, HOFS_STAT, 32'h0);
      if (r[0] === 1'b0)
        break;
    end
    if (j == 100)
      hang();
    chk("handshake", 32'(e), 32'(r[5:4]));
  endtask : xfer
  // Received IN bytes against the model queue
  task automatic got(input int n);
    int k;
    chk("count", 32'(n), 32'(r[14:8]));
    for (k = 0; k < n; k++)
    begin
      apb(1'b0, 12'h100 + 12'(4 * k), 32'h0);
      chk("byte", 32'(q[k]), 32'(r[7:0]));
    end
  endtask : got
  // Main sequence
  initial
  begin
    void'($urandom(32'h6700));
    {reg_sel, reg_wr, rsel, psel, penable, pwrite, reg_addr, reg_wdata, flg, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_IRQ_MASK, 8'h00);
    repeat (12)
    begin
      b = 8'($urandom);
      dev(1'b1, OFS_IRQ_MASK, b);
      @(posedge pclk);
      flg <= 6'($urandom);
      rsel <= 1'($urandom);
      repeat (2) @(posedge pclk);
      #1 chk("irq", 32'(|(b[5:0] & flg & {2'b11, rsel, 3'b111})), 32'(irq));
      rd(OFS_IRQ_MASK, b & MASK_BITS);
    end
    @(posedge pclk);
    flg <= 6'h00;
    dev(1'b1, OFS_EP_CSR, 8'h98);
    dev(1'b1, OFS_BASE12, 8'h01);
    dev(1'b1, OFS_CTL, 8'h03);
    xfer(TOK_IN, 3'd0, 7'h00, HS_STALL);
    xfer(TOK_SETUP, 3'd0, 7'h00, HS_ACK);
    xfer(TOK_IN, 3'd0, 7'h00, HS_NAK);
    dev(1'b1, OFS_EP0_CSR, 8'h00);
    q.delete();
    for (i = 0; i < 4; i++)
    begin
      q.push_back(8'($urandom));
      apb(1'b1, 12'h100 + 12'(4 * i), 32'(q[i]));
    end
    xfer(TOK_OUT, 3'd0, 7'h04, HS_ACK);
    rd(OFS_EP0_CSR, 8'hC4);
    for (i = 0; i < 4; i++)
      rd(OFS_EP0_DATA + 7'(i), q[i]);
    xfer(TOK_OUT, 3'd0, 7'h04, HS_NAK);
    dev(1'b1, OFS_EP0_CSR, 8'h00);
    q.delete();
    for (i = 0; i < 8; i++)
    begin
      q.push_back(8'($urandom));
      dev(1'b1, OFS_EP0_DATA + 7'(i), q[i]);
    end
    dev(1'b1, OFS_EP0_CSR, 8'h18);
    xfer(TOK_IN, 3'd0, 7'h00, HS_ACK);
    got(8);
    rd(OFS_EP0_CSR, 8'h24);
    dev(1'b1, OFS_EP0_CSR, 8'h38);
    xfer(TOK_IN, 3'd0, 7'h00, HS_NAK);
    q.delete();
    for (i = 0; i < 3; i++)
    begin
      q.push_back(8'($urandom));
      dev(1'b1, 7'(72 + i), q[i]);
    end
    dev(1'b1, OFS_EP_LEN, 8'h03);
    dev(1'b1, OFS_EP_CSR, 8'h9C);
    xfer(TOK_IN, 3'd1, 7'h00, HS_ACK);
    got(3);
    dev(1'b1, OFS_EP_CSR, 8'h8A);
    rd(OFS_EP_CSR, 8'h9A);
    chk("irq", 32'h1, 32'(irq));
    xfer(TOK_IN, 3'd1, 7'h00, HS_NAK);
    dev(1'b1, OFS_EP_CSR, 8'hB8);
    @(posedge pclk);
    #1 chk("irq", 32'h0, 32'(irq));
    xfer(TOK_IN, 3'd1, 7'h00, HS_STALL);
    rd(OFS_EP_CSR, 8'h98);
    dev(1'b1, OFS_EP_CSR, 8'h98);
    xfer(TOK_IN, 3'd1, 7'h00, HS_STALL);
    // Host request lifts the latched halt; an unlatched stall is withdrawn by software
    xfer(TOK_CLEAR_HALT, 3'd1, 7'h00, HS_ACK);
    xfer(TOK_IN, 3'd1, 7'h00, HS_NAK);
    dev(1'b1, OFS_EP_CSR, 8'hB8);
    dev(1'b1, OFS_EP_CSR, 8'h98);
    xfer(TOK_IN, 3'd1, 7'h00, HS_NAK);
    // Unmapped host address answers with an error
    apb(1'b0, 12'h008, 32'h0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
